// *** rtl/fms_mode_config.sv ***
`timescale 1ns/1ps
`default_nettype none

module fms_mode_config #(
   parameter int HOLD_LONG_CYC  = fms_pkg::HOLD_LONG_CYC,
   parameter int TICK_SHORT_CYC = fms_pkg::TICK_SHORT_CYC,
   parameter int TICK_LONG_CYC  = fms_pkg::TICK_LONG_CYC
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // avalon-mm slave
   input  wire logic [2:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output var  logic [31:0] readdata,
   output var  logic        waitrequest,
   // protocol state from the controller core
   input  wire logic        device_online,
   input  wire logic        dx_state,
   input  wire logic        dx_frame_valid,
   input  wire logic        dx_zero_length,
   // settings towards the controller core
   output var  logic        sync_supported,
   output var  logic        freeze_supported,
   output var  logic        slave_protocol_enable,
   output var  logic        service_access_points,
   output var  logic        irq_inactive_timebase,
   output var  logic        watchdog_test_select,
   output var  logic        watchdog_normal,
   output var  logic        param_direct_buffer,
   output var  logic        dx_frame_accept,
   // interrupt
   output var  logic        irq
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   // bus handshake states; one access is served at a time
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WAIT,
      BUS_ACK
   } fms_bus_state_t;

   // registers and internal nets
   fms_bus_state_t                 bus_state_reg;
   logic [15:0]                    mode_reg;
   logic [fms_pkg::EVT_WIDTH-1:0]  status_reg;
   logic [fms_pkg::EVT_WIDTH-1:0]  mask_reg;
   logic [fms_pkg::EVT_WIDTH-1:0]  event_set;
   logic [fms_pkg::EVT_WIDTH-1:0]  status_clr;
   logic [31:0]                    read_mux;
   logic [15:0]                    mode_wdata;
   logic                           bus_req;
   logic                           wr_take;
   logic                           mode_write;
   logic                           mode_refused;
   logic                           eoi_pulse;
   logic                           hold_active;
   logic                           tick;
   logic                           failsafe_hit;

   // ---------------------------------------------------------------
   // bus handshake
   // ---------------------------------------------------------------
   // any request, read or write, starts the wait-state sequence
   assign bus_req = read || write;
   // a write lands only on the edge where the master sees waitrequest low
   assign wr_take = write && (bus_state_reg == BUS_ACK);

   // wait states: two normally, one with ready advanced
   always_ff @(posedge mclk) begin
      if (reset) begin
         bus_state_reg <= BUS_IDLE;
         waitrequest   <= 1'b1;
      end else begin
         unique case (bus_state_reg)
            BUS_IDLE: begin
               if (bus_req && mode_reg[fms_pkg::MODE_READY_ADVANCE]) begin
                  bus_state_reg <= BUS_ACK;
                  waitrequest   <= 1'b0;
               end else if (bus_req) begin
                  bus_state_reg <= BUS_WAIT;
               end
            end
            BUS_WAIT: begin
               bus_state_reg <= BUS_ACK;
               waitrequest   <= 1'b0;
            end
            BUS_ACK: begin
               bus_state_reg <= BUS_IDLE;
               waitrequest   <= 1'b1;
            end
            // the fourth code of the state word is unreachable; fall back to idle
            default: begin
               bus_state_reg <= BUS_IDLE;
               waitrequest   <= 1'b1;
            end
         endcase
      end
   end

   // read mux, unmapped and write-only words read as zero
   always_comb begin
      read_mux = 32'h0000_0000;
      unique case (address)
         fms_pkg::ADDR_MODE:   read_mux = {16'h0000, mode_reg};
         fms_pkg::ADDR_STATUS: read_mux = {29'h0000_0000, status_reg};
         fms_pkg::ADDR_MASK:   read_mux = {29'h0000_0000, mask_reg};
         fms_pkg::ADDR_STATE:  read_mux = {29'h0000_0000, irq, hold_active, device_online};
         default:              read_mux = 32'h0000_0000;
      endcase
   end

   // read data captured before the ack cycle so it stands while waitrequest is low
   always_ff @(posedge mclk) begin
      if (reset) begin
         readdata <= 32'h0000_0000;
      end else if (read && (bus_state_reg != BUS_ACK)) begin
         readdata <= read_mux;
      end
   end

   // ---------------------------------------------------------------
   // primary_mode_config
   // ---------------------------------------------------------------
   // lanes 2 and 3 carry nothing, the mode word is 16 bits
   assign mode_write   = wr_take && (address == fms_pkg::ADDR_MODE) && (byteenable[1:0] != 2'h0);
   // writes while online are dropped and flagged, so software sees its mistake
   assign mode_refused = mode_write && device_online;

   // byte lanes merged into the current value
   always_comb begin
      mode_wdata = mode_reg;
      if (byteenable[0]) begin
         mode_wdata[7:0] = writedata[7:0];
      end
      if (byteenable[1]) begin
         mode_wdata[15:8] = writedata[15:8];
      end
   end

   // only the upper fields are kept; bits 0..4 and 14..15 read zero
   always_ff @(posedge mclk) begin
      if (reset) begin
         mode_reg <= fms_pkg::MODE_RESET;
      end else if (mode_write && !device_online) begin
         mode_reg <= mode_wdata & fms_pkg::MODE_WRITE_MASK;
      end
   end

   // capability flags, one clock behind the register like every setting
   always_ff @(posedge mclk) begin
      if (reset) begin
         sync_supported   <= 1'b0;
         freeze_supported <= 1'b0;
      end else begin
         sync_supported   <= mode_reg[fms_pkg::MODE_SYNC_SUPPORT];
         freeze_supported <= mode_reg[fms_pkg::MODE_FREEZE_SUPPORT];
      end
   end

   // protocol enable; the access points come up together with it
   always_ff @(posedge mclk) begin
      if (reset) begin
         slave_protocol_enable <= 1'b0;
         service_access_points <= 1'b0;
      end else begin
         slave_protocol_enable <= mode_reg[fms_pkg::MODE_SLAVE_ENABLE];
         service_access_points <= mode_reg[fms_pkg::MODE_SLAVE_ENABLE];
      end
   end

   // timebase and buffer selects; a change takes effect on the next clock
   always_ff @(posedge mclk) begin
      if (reset) begin
         irq_inactive_timebase <= 1'b0;
         param_direct_buffer   <= 1'b0;
      end else begin
         irq_inactive_timebase <= mode_reg[fms_pkg::MODE_IRQ_TIMEBASE];
         param_direct_buffer   <= mode_reg[fms_pkg::MODE_PARAM_BUFFER];
      end
   end

   // watchdog mode; bit 11 is kept as written, so a forbidden one
   // from the host shows up here instead of being hidden
   always_ff @(posedge mclk) begin
      if (reset) begin
         watchdog_test_select <= 1'b0;
         watchdog_normal      <= 1'b1;
      end else begin
         watchdog_test_select <= mode_reg[fms_pkg::MODE_WATCHDOG_TEST_SELECT];
         watchdog_normal      <= !mode_reg[fms_pkg::MODE_WATCHDOG_TEST_SELECT];
      end
   end

   // ---------------------------------------------------------------
   // zero-length frame acceptance
   // ---------------------------------------------------------------
   // status event: a zero-length frame actually taken in
   assign failsafe_hit = dx_frame_valid && dx_state && dx_zero_length && mode_reg[fms_pkg::MODE_FAILSAFE];

   // zero-length frames pass only with fail-safe set and in data exchange
   always_ff @(posedge mclk) begin
      if (reset) begin
         dx_frame_accept <= 1'b0;
      end else begin
         dx_frame_accept <= dx_frame_valid && dx_state && (!dx_zero_length || mode_reg[fms_pkg::MODE_FAILSAFE]);
      end
   end

   // ---------------------------------------------------------------
   // timers
   // ---------------------------------------------------------------
   // periodic tick; its interval follows the tick timebase bit
   fms_tick_timer #(
      .SHORT_CYC (TICK_SHORT_CYC),
      .LONG_CYC  (TICK_LONG_CYC)
   ) u_tick (
      .mclk      (mclk),
      .reset     (reset),
      .long_sel  (mode_reg[fms_pkg::MODE_TICK_TIMEBASE]),
      .tick      (tick)
   );

   // quiet time after end-of-interrupt, restarted by each eoi
   fms_irq_hold #(
      .LONG_CYC    (HOLD_LONG_CYC)
   ) u_hold (
      .mclk        (mclk),
      .reset       (reset),
      .eoi_pulse   (eoi_pulse),
      .long_sel    (mode_reg[fms_pkg::MODE_IRQ_TIMEBASE]),
      .hold_active (hold_active)
   );

   // ---------------------------------------------------------------
   // interrupt status, mask and output
   // ---------------------------------------------------------------
   // end-of-interrupt strobe, control word lane 0 bit 0
   assign eoi_pulse = wr_take && (address == fms_pkg::ADDR_CTRL) && byteenable[0] && writedata[fms_pkg::CTRL_EOI];

   // event sources of the sticky status bits
   always_comb begin
      event_set                        = '0;
      event_set[fms_pkg::EVT_TICK]     = tick;
      event_set[fms_pkg::EVT_FAILSAFE] = failsafe_hit;
      event_set[fms_pkg::EVT_REFUSED]  = mode_refused;
   end

   // write one to clear, lane 0 only
   assign status_clr = (wr_take && (address == fms_pkg::ADDR_STATUS) && byteenable[0]) ?
                       writedata[fms_pkg::EVT_WIDTH-1:0] : '0;

   // sticky bits, write one to clear; a new event wins over the clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         status_reg <= fms_pkg::EVT_RESET;
      end else begin
         status_reg <= (status_reg & ~status_clr) | event_set;
      end
   end

   // interrupt mask, same layout as the status word
   always_ff @(posedge mclk) begin
      if (reset) begin
         mask_reg <= fms_pkg::EVT_RESET;
      end else if (wr_take && (address == fms_pkg::ADDR_MASK) && byteenable[0]) begin
         mask_reg <= writedata[fms_pkg::EVT_WIDTH-1:0];
      end
   end

   // level output, forced low from the eoi edge through the quiet time
   always_ff @(posedge mclk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= (|(status_reg & mask_reg)) && !hold_active && !eoi_pulse;
      end
   end

endmodule

`default_nettype wire

// *** rtl/fms_pkg.sv ***
package fms_pkg;

   // ---------------------------------------------------------------
   // register map, word addresses on the avalon port
   // ---------------------------------------------------------------
   localparam logic [2:0] ADDR_MODE   = 3'h0;
   localparam logic [2:0] ADDR_STATUS = 3'h1;
   localparam logic [2:0] ADDR_MASK   = 3'h2;
   localparam logic [2:0] ADDR_CTRL   = 3'h3;
   localparam logic [2:0] ADDR_STATE  = 3'h4;

   // ---------------------------------------------------------------
   // primary_mode_config field positions and reset value
   // ---------------------------------------------------------------
   localparam int MODE_READY_ADVANCE  = 5;
   localparam int MODE_SYNC_SUPPORT   = 6;
   localparam int MODE_FREEZE_SUPPORT = 7;
   localparam int MODE_SLAVE_ENABLE   = 8;
   localparam int MODE_IRQ_TIMEBASE   = 9;
   localparam int MODE_TICK_TIMEBASE  = 10;
   localparam int MODE_WATCHDOG_TEST_SELECT        = 11;
   localparam int MODE_PARAM_BUFFER   = 12;
   localparam int MODE_FAILSAFE       = 13;
   localparam logic [15:0] MODE_WRITE_MASK = 16'h3fe0;
   localparam logic [15:0] MODE_RESET      = 16'h0000;

   // ---------------------------------------------------------------
   // interrupt status / mask layout
   // ---------------------------------------------------------------
   localparam int EVT_TICK     = 0;
   localparam int EVT_FAILSAFE = 1;
   localparam int EVT_REFUSED  = 2;
   localparam int EVT_WIDTH    = 3;
   localparam logic [EVT_WIDTH-1:0] EVT_RESET = 3'h0;
   localparam int CTRL_EOI     = 0;

   // ---------------------------------------------------------------
   // bus wait states
   // ---------------------------------------------------------------
   localparam int WAIT_NORMAL = 2;
   localparam int WAIT_EARLY  = 1;

   // ---------------------------------------------------------------
   // timing, times in ns, counts in mclk cycles
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 100;
   localparam int HOLD_SHORT_NS  = 1000;
   localparam int HOLD_LONG_NS   = 1000000;
   localparam int TICK_SHORT_NS  = 1000000;
   localparam int TICK_LONG_NS   = 10000000;
   localparam int HOLD_SHORT_CYC = (HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_LONG_CYC  = (HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_SHORT_CYC = TICK_SHORT_NS / CLK_PERIOD_NS;
   localparam int TICK_LONG_CYC  = TICK_LONG_NS / CLK_PERIOD_NS;
   localparam int CNT_WIDTH      = 24;

endpackage

// *** rtl/fms_irq_hold.sv ***
`timescale 1ns/1ps
`default_nettype none

module fms_irq_hold #(
   parameter int LONG_CYC = fms_pkg::HOLD_LONG_CYC
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic reset,
   // control
   input  wire logic eoi_pulse,
   input  wire logic long_sel,
   // result
   output var  logic hold_active
);

   localparam logic [fms_pkg::CNT_WIDTH-1:0] SHORT_LOAD = fms_pkg::CNT_WIDTH'(fms_pkg::HOLD_SHORT_CYC);
   localparam logic [fms_pkg::CNT_WIDTH-1:0] LONG_LOAD  = fms_pkg::CNT_WIDTH'(LONG_CYC);

   logic [fms_pkg::CNT_WIDTH-1:0] cnt_reg;

   // an eoi restarts the count, so back-to-back eois stretch the quiet time
   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_reg <= '0;
      end else if (eoi_pulse) begin
         cnt_reg <= long_sel ? LONG_LOAD : SHORT_LOAD;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   // registered flag, high exactly while the count is non-zero
   always_ff @(posedge mclk) begin
      if (reset) begin
         hold_active <= 1'b0;
      end else begin
         hold_active <= eoi_pulse || (cnt_reg > 24'h000001);
      end
   end

endmodule

`default_nettype wire

// *** rtl/fms_tick_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

module fms_tick_timer #(
   parameter int SHORT_CYC = fms_pkg::TICK_SHORT_CYC,
   parameter int LONG_CYC  = fms_pkg::TICK_LONG_CYC
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic reset,
   // control
   input  wire logic long_sel,
   // result
   output var  logic tick
);

   localparam logic [fms_pkg::CNT_WIDTH-1:0] SHORT_LAST = fms_pkg::CNT_WIDTH'(SHORT_CYC - 1);
   localparam logic [fms_pkg::CNT_WIDTH-1:0] LONG_LAST  = fms_pkg::CNT_WIDTH'(LONG_CYC - 1);

   logic [fms_pkg::CNT_WIDTH-1:0] cnt_reg;
   logic                          sel_reg;
   logic                          wrap;

   // a timebase change restarts the period so no short stray tick appears
   assign wrap = (cnt_reg >= (long_sel ? LONG_LAST : SHORT_LAST));

   // free running period counter
   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_reg <= '0;
         sel_reg <= 1'b0;
      end else begin
         sel_reg <= long_sel;
         if (wrap || (sel_reg != long_sel)) begin
            cnt_reg <= '0;
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

   // one-cycle tick at the end of each period
   always_ff @(posedge mclk) begin
      if (reset) begin
         tick <= 1'b0;
      end else begin
         tick <= wrap && (sel_reg == long_sel);
      end
   end

endmodule

`default_nettype wire

// *** dv/fms_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module fms_host_model (
   // clock
   input  wire logic        mclk,
   // avalon-mm request
   output var  logic [2:0]  address,
   output var  logic        read,
   output var  logic        write,
   output var  logic [3:0]  byteenable,
   output var  logic [31:0] writedata,
   // slave answer
   input  wire logic [31:0] readdata,
   input  wire logic        waitrequest
);
   // idle bus at time zero
   initial begin
      address = 3'h7;
      read = 1'b0;
      write = 1'b0;
      byteenable = 4'h0;
      writedata = 32'h0;
   end

   // one transfer; afterwards address and write data show the inverse so stale values never match
   task automatic xfer(input logic w, input logic [2:0] a, input logic [3:0] be,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      address    <= a;
      byteenable <= be;
      writedata  <= (w && a == fms_pkg::ADDR_MODE) ? (d & ~32'h800) : d;
      read       <= !w;
      write      <= w;
      do @(posedge mclk); while (waitrequest !== 1'b0);
      q = readdata;
      read      <= 1'b0;
      write     <= 1'b0;
      address   <= ~a;
      writedata <= ~d;
   endtask
endmodule

`default_nettype wire

// *** dv/fms_mode_config_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module fms_mode_config_chk #(
   parameter int HOLD_LONG_CYC = fms_pkg::HOLD_LONG_CYC
) (
   // clock, reset, bus
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic [2:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // core side
   input wire logic        device_online,
   input wire logic        dx_state,
   input wire logic        dx_frame_valid,
   input wire logic        dx_zero_length,
   input wire logic        sync_supported,
   input wire logic        freeze_supported,
   input wire logic        slave_protocol_enable,
   input wire logic        service_access_points,
   input wire logic        irq_inactive_timebase,
   input wire logic        watchdog_test_select,
   input wire logic        watchdog_normal,
   input wire logic        param_direct_buffer,
   input wire logic        dx_frame_accept,
   input wire logic        irq
);
   logic [15:0] mode_q;
   logic [15:0] lane;
   logic [19:0] hold_cnt;
   logic        wr_ack;
   logic        take_ok;

   // shadow of the mode word, offline writes only
   assign wr_ack = write && !waitrequest;
   assign lane = {{8{byteenable[1]}}, {8{byteenable[0]}}} & fms_pkg::MODE_WRITE_MASK;
   always_ff @(posedge mclk) begin
      if (reset) begin
         mode_q <= fms_pkg::MODE_RESET;
      end else if (wr_ack && address == fms_pkg::ADDR_MODE && !device_online) begin
         mode_q <= (mode_q & ~lane) | (writedata[15:0] & lane);
      end
   end

   // inactive-time countdown after end-of-interrupt
   always_ff @(posedge mclk) begin
      if (reset) begin
         hold_cnt <= 20'h0;
      end else if (wr_ack && address == fms_pkg::ADDR_CTRL && byteenable[0] && writedata[0]) begin
         hold_cnt <= mode_q[9] ? 20'(HOLD_LONG_CYC) : 20'(fms_pkg::HOLD_SHORT_CYC);
      end else if (hold_cnt != 20'h0) begin
         hold_cnt <= hold_cnt - 20'h1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_start;
      $rose(read || write);
   endsequence
   sequence s_ack_early;
      waitrequest ##1 !waitrequest;
   endsequence
   sequence s_ack_late;
      waitrequest ##1 s_ack_early;
   endsequence

   // the request edge still sees waitrequest high, the drop is registered
   chk_ack_late: assert property (s_start ##0 !mode_q[5] |-> s_ack_late)
      else $error("late ready timing wrong");
   chk_ack_early: assert property (s_start ##0 mode_q[5] |-> s_ack_early)
      else $error("early ready timing wrong");
   chk_ack_single: assert property (!waitrequest |=> waitrequest)
      else $error("ready longer than one cycle");
   chk_mode_readback: assert property (read && !waitrequest && address == fms_pkg::ADDR_MODE
      |-> readdata == {16'h0, mode_q})
      else $error("mode readback wrong");
   chk_settings_follow: assert property ({sync_supported, freeze_supported, slave_protocol_enable,
      service_access_points, irq_inactive_timebase, param_direct_buffer} == $past({mode_q[6], mode_q[7], mode_q[8],
      mode_q[8], mode_q[9], mode_q[12]}))
      else $error("settings differ from mode word");
   chk_watchdog_mode: assert property (watchdog_normal == !$past(mode_q[11])
      && watchdog_test_select == $past(mode_q[11]))
      else $error("watchdog mode wrong");
   // frames the rules let through
   assign take_ok = dx_frame_valid && dx_state && (!dx_zero_length || mode_q[13]);
   chk_accept_yes: assert property (take_ok |=> dx_frame_accept)
      else $error("frame not accepted");
   chk_accept_no: assert property (!take_ok |=> !dx_frame_accept)
      else $error("frame accepted wrongly");
   chk_eoi_hold: assert property (hold_cnt != 20'h0 && $past(hold_cnt) != 20'h0 |-> !irq)
      else $error("interrupt during inactive time");
endmodule

bind fms_mode_config fms_mode_config_chk #(.HOLD_LONG_CYC(HOLD_LONG_CYC)) fms_mode_config_chk_inst (
   .mclk, .reset, .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .device_online,
   .dx_state, .dx_frame_valid, .dx_zero_length, .sync_supported, .freeze_supported, .slave_protocol_enable,
   .service_access_points, .irq_inactive_timebase, .watchdog_test_select, .watchdog_normal, .param_direct_buffer,
   .dx_frame_accept, .irq);

`default_nettype wire

// *** dv/fms_mode_config_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module fms_mode_config_tb_top;
   localparam int TICK_S = 30;
   localparam int TICK_L = 60;
   localparam int HOLD_L = 20;
   logic mclk = 1'b0, reset = 1'b1, device_online = 1'b0;
   logic dx_state = 1'b0, dx_frame_valid = 1'b0, dx_zero_length = 1'b0;
   logic [2:0] address;
   logic read, write, waitrequest, irq, dx_frame_accept;
   logic [3:0] byteenable;
   logic [31:0] writedata, readdata, q, rng = 32'd20776;
   logic sync_supported, freeze_supported, slave_protocol_enable, service_access_points;
   logic irq_inactive_timebase, watchdog_test_select, watchdog_normal, param_direct_buffer;
   logic [15:0] mode_exp = 16'h0;
   int n_fail = 0, checks_done = 0, cyc = 0, c0;

   always #50 mclk = ~mclk;

   fms_mode_config #(.HOLD_LONG_CYC(HOLD_L), .TICK_SHORT_CYC(TICK_S), .TICK_LONG_CYC(TICK_L)) fms_mode_config_inst (
      .mclk, .reset, .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .device_online,
      .dx_state, .dx_frame_valid, .dx_zero_length, .sync_supported, .freeze_supported, .slave_protocol_enable,
      .service_access_points, .irq_inactive_timebase, .watchdog_test_select, .watchdog_normal,
      .param_direct_buffer, .dx_frame_accept, .irq);
   fms_host_model fms_host_model_inst (.mclk, .address, .read, .write, .byteenable, .writedata, .readdata,
      .waitrequest);

   function automatic logic [31:0] nxt(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // expected mode word after a lane-masked write
   function automatic logic [15:0] mode_after(input logic [15:0] old, input logic [15:0] d, input logic [3:0] be);
      logic [15:0] m;
      m = {{8{be[1]}}, {8{be[0]}}} & fms_pkg::MODE_WRITE_MASK;
      return (old & ~m) | (d & m);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic results;
      if (n_fail == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [2:0] a, input logic [3:0] be, input logic [31:0] d);
      logic [31:0] unused;
      fms_host_model_inst.xfer(1'b1, a, be, d, unused);
   endtask

   // bounded wait, sampled mid-cycle where the level has settled
   task automatic wait_irq(input logic lvl);
      int n;
      n = 0;
      while (irq !== lvl && n < 1000) begin
         @(negedge mclk);
         n++;
      end
      check(32'(n < 1000), 32'h1);
   endtask

   // hang guard: the whole sequence needs a few hundred cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end

   initial begin
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      fms_host_model_inst.xfer(1'b0, fms_pkg::ADDR_MODE, 4'hf, 32'h0, q);
      check(q, 32'h0);
      check(32'({watchdog_normal, watchdog_test_select}), 32'h2);
      // random offline writes, random lanes, bit 11 never set
      for (int i = 0; i < 12; i++) begin
         rng = nxt(rng);
         wr(fms_pkg::ADDR_MODE, rng[19:16], {16'h0, rng[15:0] & 16'h37e0});
         mode_exp = mode_after(mode_exp, rng[15:0] & 16'h37e0, rng[19:16]);
         fms_host_model_inst.xfer(1'b0, fms_pkg::ADDR_MODE, 4'hf, 32'h0, q);
         check(q, {16'h0, mode_exp});
         check(32'({sync_supported, freeze_supported, slave_protocol_enable, service_access_points}),
               32'({mode_exp[6], mode_exp[7], mode_exp[8], mode_exp[8]}));
         check(32'({irq_inactive_timebase, param_direct_buffer}), 32'({mode_exp[9], mode_exp[12]}));
      end
      // mode write while online is refused and flagged
      device_online <= 1'b1;
      wr(fms_pkg::ADDR_MODE, 4'h3, {16'h0, ~mode_exp & 16'h37e0});
      fms_host_model_inst.xfer(1'b0, fms_pkg::ADDR_MODE, 4'hf, 32'h0, q);
      check(q, {16'h0, mode_exp});
      fms_host_model_inst.xfer(1'b0, fms_pkg::ADDR_STATUS, 4'hf, 32'h0, q);
      check(q & 32'h4, 32'h4);
      device_online <= 1'b0;
      // zero-length frames with fail-safe off and on
      for (int t = 0; t < 2; t++) begin
         mode_exp[13] = t[0];
         wr(fms_pkg::ADDR_MODE, 4'h3, {16'h0, mode_exp});
         for (int i = 0; i < 8; i++) begin
            rng = nxt(rng);
            @(posedge mclk);
            dx_state <= rng[0];
            dx_zero_length <= rng[1];
            dx_frame_valid <= 1'b1;
            @(posedge mclk);
            dx_frame_valid <= 1'b0;
            @(negedge mclk);
            check(32'(dx_frame_accept), 32'(rng[0] && (!rng[1] || t[0])));
         end
      end
      // tick interval and end-of-interrupt hold, both timebases
      for (int t = 0; t < 2; t++) begin
         mode_exp[10:9] = {2{t[0]}};
         // flipping the tick timebase restarts the period, so no tick lands in the setup writes
         wr(fms_pkg::ADDR_MODE, 4'h3, {16'h0, mode_exp ^ 16'h0400});
         wr(fms_pkg::ADDR_MODE, 4'h3, {16'h0, mode_exp});
         // stale status cleared before unmasking, so the first rise is a fresh tick
         wr(fms_pkg::ADDR_STATUS, 4'h1, 32'h7);
         wr(fms_pkg::ADDR_MASK, 4'h1, 32'h1);
         wait_irq(1'b1);
         c0 = cyc;
         wr(fms_pkg::ADDR_STATUS, 4'h1, 32'h1);
         wait_irq(1'b0);
         wait_irq(1'b1);
         check(32'(cyc - c0), t ? 32'(TICK_L) : 32'(TICK_S));
         wr(fms_pkg::ADDR_CTRL, 4'h1, 32'h1);
         c0 = cyc;
         wait_irq(1'b0);
         wait_irq(1'b1);
         check(32'(cyc - c0 >= (t ? HOLD_L : fms_pkg::HOLD_SHORT_CYC)), 32'h1);
      end
      // masked status keeps the line low
      wr(fms_pkg::ADDR_MASK, 4'h1, 32'h0);
      repeat (2) @(negedge mclk);
      check(32'(irq), 32'h0);
      fms_host_model_inst.xfer(1'b0, fms_pkg::ADDR_STATUS, 4'hf, 32'h0, q);
      check(q & 32'h1, 32'h1);
      results();
   end
endmodule

`default_nettype wire
